// *** spd_pkg.sv ***
// Shared constants and types for the presence-detect serial memory slave.
// Assumes a single 20 MHz clock; all bus pins are synchronous to it.
package spd_pkg;

    // --------------------
    // Addressing and organisation
    // --------------------
    localparam logic [3:0] MEM_TYPE_CODE = 4'ha;
    localparam logic [3:0] CTRL_TYPE_CODE = 4'h6;
    localparam int MEM_BYTES = 512;
    localparam int PAGE_BYTES = 256;
    localparam int BLOCK_BYTES = 128;
    localparam int BLOCK_COUNT = 4;
    localparam int WRITE_PAGE_BYTES = 16;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Select-address field of a control-type select byte.
    localparam logic [2:0] CMD_PROTECT_0 = 3'h1;
    localparam logic [2:0] CMD_PROTECT_1 = 3'h4;
    localparam logic [2:0] CMD_PROTECT_2 = 3'h5;
    localparam logic [2:0] CMD_PROTECT_3 = 3'h0;
    localparam logic [2:0] CMD_CLEAR_PROTECT = 3'h3;
    localparam logic [2:0] CMD_PAGE_0 = 3'h6;
    localparam logic [2:0] CMD_PAGE_1 = 3'h7;

    // --------------------
    // Bit timing within a byte
    // --------------------
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [3:0] BIT_ZERO = 4'h0;

    // --------------------
    // Timing
    // --------------------
    localparam int CLOCK_KHZ = 20000;
    localparam int WRITE_TIME_US = 5000;
    localparam int PROG_CYCLES_DEF = WRITE_TIME_US * CLOCK_KHZ / 1000;
    localparam int BUS_TIMEOUT_US = 25000;
    localparam int TIMEOUT_CYCLES_DEF = BUS_TIMEOUT_US * CLOCK_KHZ / 1000;
    localparam int TIMER_BITS = 24;
    localparam int FIFO_DEPTH = 4;

    // --------------------
    // Types
    // --------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_SELECT = 3'h1,
        ST_WORD = 3'h3,
        ST_WRITE = 3'h2,
        ST_READ = 3'h6,
        ST_CTRL = 3'h7
    } spd_state_t;

    typedef struct packed {
        logic [3:0] offset;
        logic [7:0] data;
    } spd_wr_word_t;

    localparam int WR_WORD_BITS = $bits(spd_wr_word_t);

endpackage : spd_pkg

// *** spd_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
module spd_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;

    assign in_ready = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = store[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            store[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end

endmodule : spd_fifo

// *** spd_eeprom_slave.sv ***
// Two-wire slave front end, write buffering, programming timer, block
// protection and page selection of a 512-byte presence-detect memory.
// Assumes scl and sda_in are already synchronous to the 20 MHz clock and
// that the pad combines sda_out and sda_oe into an open-drain wire.
`timescale 1ns/100ps

// Notes on behaviour
// - 512 bytes stored as two 256-byte pages.
// - Four 128-byte blocks, each lockable alone.
// - Byte writes and partial pages to sixteen.
// - Self-timed programming: five ms wait, then a 16-clock commit.
// - Supply-low ignores bus; release enters standby.
// - Supply falling aborts activity, enters standby; a programming cycle already running still completes.
// - Stop returns standby unless programming runs.
// - Select pins compared with address bits three-one.
// - Protect commands need high voltage on pin 0.
// - Page state steers legacy commands to page.
// - Data line only pulled low or released.
// - Bits sampled and launched by serial clock.
// - Stalled clock abandons transfer, releases data.
// - Type 1010 memory, 0110 protection and page.
// - Serial clock is input only, never stretched.
// - Stop after write data starts programming.
// - Ack on match; mismatch deselects to standby.
module spd_eeprom_slave #(
    parameter int PROG_CYCLES = spd_pkg::PROG_CYCLES_DEF,
    parameter int TIMEOUT_CYCLES = spd_pkg::TIMEOUT_CYCLES_DEF
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_ok,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_addr_pin_0,
    input wire logic select_addr_pin_1,
    input wire logic select_addr_pin_2,
    input wire logic high_voltage_level,
    output logic prog_busy,
    output logic active_page
);
    // --------------------
    // Storage and status
    // --------------------
    logic [7:0] mem [spd_pkg::MEM_BYTES];
    logic [spd_pkg::BLOCK_COUNT-1:0] block_lock;
    logic [7:0] pb_data [spd_pkg::WRITE_PAGE_BYTES];
    logic [spd_pkg::WRITE_PAGE_BYTES-1:0] pb_valid;
    logic [4:0] pb_base;
    logic [3:0] commit_idx;
    logic committing;
    logic [spd_pkg::TIMER_BITS-1:0] prog_timer;

    // --------------------
    // Bus protocol state
    // --------------------
    spd_pkg::spd_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] addr;
    logic scl_q;
    logic sda_q;
    logic [spd_pkg::TIMER_BITS-1:0] stall_cnt;
    logic pending_write;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic timed_out;
    logic [2:0] logical_select_address;
    logic byte_done;
    logic ack_done;
    logic write_blocked;
    logic fifo_in_ready;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic fifo_out_ready;
    spd_pkg::spd_wr_word_t fifo_in;
    spd_pkg::spd_wr_word_t fifo_out;
    logic [8:0] mem_index;
    logic [8:0] commit_index;
    logic prog_done;

    assign scl_rise = scl && !scl_q;
    assign scl_fall = !scl && scl_q;
    assign start_seen = scl && scl_q && sda_q && !sda_in;
    assign stop_seen = scl && scl_q && !sda_q && sda_in;
    assign timed_out = stall_cnt == spd_pkg::TIMER_BITS'(TIMEOUT_CYCLES - 1);
    assign logical_select_address = {select_addr_pin_2, select_addr_pin_1, select_addr_pin_0};
    assign byte_done = scl_fall && bit_cnt == spd_pkg::DATA_BITS;
    assign ack_done = scl_fall && bit_cnt == spd_pkg::ACK_SLOT;
    assign mem_index = {active_page, addr};
    assign write_blocked = block_lock[{active_page, addr[7]}];
    assign fifo_in = '{offset: addr[3:0], data: shreg};
    assign fifo_in_valid = byte_done && state == spd_pkg::ST_WRITE && !write_blocked;
    assign fifo_out_ready = !committing;
    assign commit_index = {pb_base, commit_idx};
    assign prog_done = prog_timer == spd_pkg::TIMER_BITS'(PROG_CYCLES - 1);

    // The line is only ever pulled low, never driven high.
    assign sda_out = 1'b0;

    // --------------------
    // Pin history and stall watchdog
    // --------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda_in;
        end
    end

    // Only a clock held low inside a transfer counts as a stall.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stall_cnt <= '0;
        end else if (scl || state == spd_pkg::ST_IDLE || timed_out) begin
            stall_cnt <= '0;
        end else begin
            stall_cnt <= stall_cnt + spd_pkg::TIMER_BITS'(1);
        end
    end

    // --------------------
    // Byte-level protocol
    // --------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= spd_pkg::ST_IDLE;
            bit_cnt <= spd_pkg::BIT_ZERO;
            shreg <= '0;
            addr <= '0;
            sda_oe <= 1'b0;
            pending_write <= 1'b0;
        end else if (!supply_ok || timed_out) begin
            state <= spd_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            pending_write <= 1'b0;
        end else if (start_seen) begin
            state <= spd_pkg::ST_SELECT;
            bit_cnt <= spd_pkg::BIT_ZERO;
            sda_oe <= 1'b0;
            pending_write <= 1'b0;
        end else if (stop_seen) begin
            state <= spd_pkg::ST_IDLE;
            sda_oe <= 1'b0;
            pending_write <= 1'b0;
        end else if (state != spd_pkg::ST_IDLE) begin
            if (scl_rise) begin
                if (bit_cnt == spd_pkg::DATA_BITS) begin
                    // Master answers a read byte; a release ends the read.
                    if (state == spd_pkg::ST_READ && sda_in) begin
                        state <= spd_pkg::ST_IDLE;
                    end
                end else if (state == spd_pkg::ST_READ) begin
                    shreg <= {shreg[6:0], 1'b0};
                end else begin
                    shreg <= {shreg[6:0], sda_in};
                end
                bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
                sda_oe <= 1'b0;
                unique case (state)
                    spd_pkg::ST_SELECT: begin
                        if (prog_busy) begin
                            state <= spd_pkg::ST_IDLE;
                        end else if (shreg[7:4] == spd_pkg::MEM_TYPE_CODE &&
                                     shreg[3:1] == logical_select_address) begin
                            sda_oe <= 1'b1;
                            state <= shreg[0] ? spd_pkg::ST_READ : spd_pkg::ST_WORD;
                        end else if (shreg[7:4] == spd_pkg::CTRL_TYPE_CODE && !shreg[0]) begin
                            if (ctrl_ok(shreg[3:1], high_voltage_level)) begin
                                sda_oe <= 1'b1;
                                state <= spd_pkg::ST_CTRL;
                            end else begin
                                state <= spd_pkg::ST_IDLE;
                            end
                        end else begin
                            state <= spd_pkg::ST_IDLE;
                        end
                    end
                    spd_pkg::ST_WORD: begin
                        addr <= shreg;
                        sda_oe <= 1'b1;
                        state <= spd_pkg::ST_WRITE;
                    end
                    spd_pkg::ST_WRITE: begin
                        // Locked blocks or a full buffer refuse the byte.
                        if (write_blocked || !fifo_in_ready) begin
                            state <= spd_pkg::ST_IDLE;
                            pending_write <= 1'b0;
                        end else begin
                            sda_oe <= 1'b1;
                            pending_write <= 1'b1;
                            addr <= {addr[7:4], addr[3:0] + 4'h1};
                        end
                    end
                    spd_pkg::ST_READ: begin
                        addr <= addr + 8'h01;
                    end
                    spd_pkg::ST_CTRL: begin
                        sda_oe <= 1'b1;
                    end
                    default: begin
                        state <= spd_pkg::ST_IDLE;
                    end
                endcase
            end else if (ack_done) begin
                bit_cnt <= spd_pkg::BIT_ZERO;
                if (state == spd_pkg::ST_READ) begin
                    shreg <= mem[mem_index];
                    sda_oe <= !mem[mem_index][7];
                end else begin
                    sda_oe <= 1'b0;
                end
            end else if (scl_fall && state == spd_pkg::ST_READ &&
                         bit_cnt != spd_pkg::BIT_ZERO) begin
                sda_oe <= !shreg[7];
            end
        end
    end

    function automatic logic ctrl_ok(input logic [2:0] cmd, input logic hv);
        logic protect;
        protect = cmd == spd_pkg::CMD_PROTECT_0 || cmd == spd_pkg::CMD_PROTECT_1 ||
                  cmd == spd_pkg::CMD_PROTECT_2 || cmd == spd_pkg::CMD_PROTECT_3 ||
                  cmd == spd_pkg::CMD_CLEAR_PROTECT;
        return protect ? hv : (cmd == spd_pkg::CMD_PAGE_0 || cmd == spd_pkg::CMD_PAGE_1);
    endfunction : ctrl_ok

    // --------------------
    // Protection and page selection
    // --------------------
    // Applied when the select byte is accepted, so the new setting is in
    // force for the next transfer.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            block_lock <= '0;
            active_page <= 1'b0;
        end else if (byte_done && state == spd_pkg::ST_SELECT && supply_ok && !prog_busy &&
                     shreg[7:4] == spd_pkg::CTRL_TYPE_CODE && !shreg[0] &&
                     ctrl_ok(shreg[3:1], high_voltage_level)) begin
            unique case (shreg[3:1])
                spd_pkg::CMD_PROTECT_0: block_lock[0] <= 1'b1;
                spd_pkg::CMD_PROTECT_1: block_lock[1] <= 1'b1;
                spd_pkg::CMD_PROTECT_2: block_lock[2] <= 1'b1;
                spd_pkg::CMD_PROTECT_3: block_lock[3] <= 1'b1;
                spd_pkg::CMD_CLEAR_PROTECT: block_lock <= '0;
                spd_pkg::CMD_PAGE_0: active_page <= 1'b0;
                spd_pkg::CMD_PAGE_1: active_page <= 1'b1;
                default: active_page <= active_page;
            endcase
        end
    end

    // --------------------
    // Write staging: FIFO into a sixteen-byte page latch
    // --------------------
    spd_fifo #(
        .WIDTH(spd_pkg::WR_WORD_BITS),
        .DEPTH(spd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pb_base <= '0;
        end else if (byte_done && state == spd_pkg::ST_WORD) begin
            pb_base <= {active_page, shreg[7:4]};
        end
    end

    for (genvar i = 0; i < spd_pkg::WRITE_PAGE_BYTES; i++) begin : g_pb
        always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
                pb_valid[i] <= 1'b0;
                pb_data[i] <= '0;
            end else if (fifo_out_valid && fifo_out_ready && fifo_out.offset == 4'(i)) begin
                pb_valid[i] <= 1'b1;
                pb_data[i] <= fifo_out.data;
            end else if (byte_done && state == spd_pkg::ST_WORD) begin
                pb_valid[i] <= 1'b0;
            end else if (committing && commit_idx == 4'(i)) begin
                pb_valid[i] <= 1'b0;
            end
        end
    end

    // --------------------
    // Self-timed programming cycle
    // --------------------
    // The bus is refused for the whole cycle: the wait alone fills the whole
    // programming time, and the sixteen-cycle commit sweep runs after it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prog_busy <= 1'b0;
            committing <= 1'b0;
            prog_timer <= '0;
            commit_idx <= '0;
        end else if (!prog_busy) begin
            if (stop_seen && supply_ok && state == spd_pkg::ST_WRITE && pending_write) begin
                prog_busy <= 1'b1;
                prog_timer <= '0;
            end
        end else if (!committing) begin
            if (prog_done) begin
                committing <= 1'b1;
                commit_idx <= '0;
            end else begin
                prog_timer <= prog_timer + spd_pkg::TIMER_BITS'(1);
            end
        end else if (commit_idx == 4'(spd_pkg::WRITE_PAGE_BYTES - 1)) begin
            committing <= 1'b0;
            prog_busy <= 1'b0;
        end else begin
            commit_idx <= commit_idx + 4'h1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int j = 0; j < spd_pkg::MEM_BYTES; j++) begin
                mem[j] <= spd_pkg::ERASED_BYTE;
            end
        end else if (committing && pb_valid[commit_idx]) begin
            mem[commit_index] <= pb_data[commit_idx];
        end
    end

endmodule : spd_eeprom_slave

// *** spd_eeprom_slave_properties.sv ***
// Port checks for the presence-detect memory slave.
// Assumes one clock domain; bound to the slave after the module.
`timescale 1ns/100ps
module spd_eeprom_slave_properties #(
    parameter int PROG_CYCLES = 50,
    parameter int TIMEOUT_CYCLES = 200
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_ok,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic prog_busy,
    input wire logic active_page
);
    logic [23:0] busy_cnt;
    logic [23:0] low_cnt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_cnt <= '0;
        end else if (prog_busy) begin
            busy_cnt <= busy_cnt + 24'h1;
        end else begin
            busy_cnt <= '0;
        end
    end

    // Saturates, so a long low clock never wraps under the limit.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            low_cnt <= '0;
        end else if (scl) begin
            low_cnt <= '0;
        end else if (low_cnt != 24'hffffff) begin
            low_cnt <= low_cnt + 24'h1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_data_never_high: assert property (sda_out == 1'b0)
        else $error("data output not low");
    a_supply_low_release: assert property (!supply_ok |=> !sda_oe)
        else $error("data held while supply low");
    a_oe_clock_low: assert property (
        $changed(sda_oe) && supply_ok && $past(supply_ok) |-> !scl)
        else $error("data enable moved while clock high");
    a_prog_length: assert property (
        $fell(prog_busy) |-> busy_cnt == 24'(PROG_CYCLES + 16))
        else $error("programming length wrong");
    a_prog_bounded: assert property (busy_cnt <= 24'(PROG_CYCLES + 16))
        else $error("programming overran");
    a_prog_after_stop: assert property ($rose(prog_busy) |-> scl && sda_in)
        else $error("programming began outside a stop");
    a_timeout_release: assert property (
        low_cnt >= 24'(TIMEOUT_CYCLES + 2) |-> !sda_oe)
        else $error("data held after bus timeout");
    a_reset_standby: assert property (
        $fell(rst) |-> !sda_oe && !prog_busy && !active_page)
        else $error("outputs not idle after reset");
    a_page_quiet: assert property (
        $changed(active_page) |-> !prog_busy && supply_ok)
        else $error("page moved while busy");
endmodule : spd_eeprom_slave_properties

bind spd_eeprom_slave spd_eeprom_slave_properties #(
    .PROG_CYCLES(PROG_CYCLES),
    .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) spd_eeprom_slave_properties_inst (
    .clock(clock), .rst(rst), .supply_ok(supply_ok), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .prog_busy(prog_busy), .active_page(active_page)
);

// *** spd_bus_master.sv ***
// Bus master model: makes the serial clock and shares the data wire.
// Assumes a pull-up on the wire; the slave can only pull it low.
`timescale 1ns/100ps
module spd_bus_master (
    input wire logic clock,
    input wire logic sda_oe,
    output logic scl,
    output logic sda_in
);
    logic sda_drv = 1'b1;

    // The clock rests high between frames; only the master moves it.
    initial begin
        scl = 1'b1;
    end

    assign sda_in = sda_drv & ~sda_oe;

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick

    task automatic start_cond();
        sda_drv = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b0;
        tick(3);
        scl = 1'b0;
        tick(2);
    endtask : start_cond

    task automatic stop_cond();
        sda_drv = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        sda_drv = 1'b1;
        tick(3);
    endtask : stop_cond

    task automatic bit_io(input logic tx, output logic rx);
        sda_drv = tx;
        tick(2);
        scl = 1'b1;
        tick(2);
        rx = sda_in;
        tick(2);
        scl = 1'b0;
        tick(2);
    endtask : bit_io

    // Eight bits most significant first, then the acknowledge slot.
    task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
        output logic ack_rx);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_tx, r);
        ack_rx = ~r;
    endtask : byte_io
endmodule : spd_bus_master

// *** tb.sv ***
// Self-checking bench for the presence-detect memory slave.
// Assumes the bus master model and the port checker are compiled alongside.
`timescale 1ns/100ps
module tb;
    localparam int PROG = 400;
    localparam int TMO = 200;
    localparam logic [2:0] PINS = 3'h5;
    logic clock, rst = 1'b1, supply_ok = 1'b1, hv = 1'b0;
    logic scl, sda_in, sda_out, sda_oe, prog_busy, active_page;
    int fail_count = 0;
    int cmp_count = 0;

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    spd_eeprom_slave #(.PROG_CYCLES(PROG), .TIMEOUT_CYCLES(TMO)) spd_eeprom_slave_inst (
        .clock(clock), .rst(rst), .supply_ok(supply_ok), .scl(scl), .sda_in(sda_in),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_addr_pin_0(PINS[0]),
        .select_addr_pin_1(PINS[1]), .select_addr_pin_2(PINS[2]),
        .high_voltage_level(hv), .prog_busy(prog_busy), .active_page(active_page)
    );
    spd_bus_master spd_bus_master_inst (
        .clock(clock), .sda_oe(sda_oe), .scl(scl), .sda_in(sda_in)
    );

    function automatic logic [7:0] mem_sel(input logic rd);
        return {spd_pkg::MEM_TYPE_CODE, PINS, rd};
    endfunction : mem_sel

    function automatic logic [7:0] ctl(input logic [2:0] cmd);
        return {spd_pkg::CTRL_TYPE_CODE, cmd, 1'b0};
    endfunction : ctl

    task automatic check_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check_byte

    task automatic tick(input int n);
        spd_bus_master_inst.tick(n);
    endtask : tick

    task automatic stop();
        spd_bus_master_inst.stop_cond();
    endtask : stop

    task automatic send(input logic [7:0] b, output logic ack);
        logic [7:0] rx;
        spd_bus_master_inst.byte_io(b, 1'b1, rx, ack);
    endtask : send

    task automatic select(input logic [7:0] b, input logic exp_ack);
        logic ack;
        spd_bus_master_inst.start_cond();
        send(b, ack);
        check_bit(ack, exp_ack, "select ack");
    endtask : select

    task automatic open_read(input logic [7:0] a);
        logic ack;
        select(mem_sel(1'b0), 1'b1);
        send(a, ack);
        check_bit(ack, 1'b1, "address ack");
        select(mem_sel(1'b1), 1'b1);
    endtask : open_read

    task automatic write_mem(input logic [7:0] a, input logic [7:0] d[$], input logic exp_ack);
        logic ack;
        select(mem_sel(1'b0), 1'b1);
        send(a, ack);
        check_bit(ack, 1'b1, "address ack");
        foreach (d[i]) begin
            send(d[i], ack);
            check_bit(ack, exp_ack, "data ack");
        end
        stop();
    endtask : write_mem

    task automatic read_mem(input logic [7:0] a, input logic [7:0] exp[$]);
        logic ack;
        logic [7:0] rx;
        open_read(a);
        foreach (exp[i]) begin
            spd_bus_master_inst.byte_io(8'hff, (i == exp.size() - 1), rx, ack);
            check_byte(rx, exp[i], "read data");
        end
        stop();
    endtask : read_mem

    // An unknown expectation skips the busy-after-stop check; the end-of-cycle check still runs.
    task automatic finish_prog(input logic started);
        if (started !== 1'bx) begin
            check_bit(prog_busy, started, "busy after stop");
        end
        for (int i = 0; i < PROG + 40 && prog_busy === 1'b1; i++) begin
            tick(1);
        end
        check_bit(prog_busy, 1'b0, "busy at end");
    endtask : finish_prog

    task automatic t_write_wrap();
        write_mem(8'h0e, '{8'h11, 8'h22, 8'h33}, 1'b1);
        finish_prog(1'b1);
        read_mem(8'h0e, '{8'h11, 8'h22, 8'hff});
        read_mem(8'h00, '{8'h33, 8'hff});
    endtask : t_write_wrap

    task automatic t_busy_refuse();
        write_mem(8'h40, '{8'h44}, 1'b1);
        select(mem_sel(1'b0), 1'b0);
        stop();
        finish_prog(1'b1);
        read_mem(8'h40, '{8'h44});
    endtask : t_busy_refuse

    task automatic t_address_refuse();
        logic [7:0] bad[3] = '{{spd_pkg::MEM_TYPE_CODE, PINS ^ 3'h1, 1'b0},
            {4'h5, PINS, 1'b0}, ctl(spd_pkg::CMD_PAGE_0) | 8'h01};
        foreach (bad[i]) begin
            select(bad[i], 1'b0);
            stop();
        end
        read_mem(8'h40, '{8'h44});
    endtask : t_address_refuse

    task automatic t_protect();
        logic [2:0] locks[4] = '{spd_pkg::CMD_PROTECT_0, spd_pkg::CMD_PROTECT_1,
            spd_pkg::CMD_PROTECT_2, spd_pkg::CMD_PROTECT_3};
        select(ctl(spd_pkg::CMD_PROTECT_0), 1'b0);
        stop();
        hv = 1'b1;
        foreach (locks[i]) begin
            select(ctl(locks[i]), 1'b1);
            stop();
            finish_prog(1'bx);
        end
        hv = 1'b0;
        write_mem(8'h05, '{8'haa}, 1'b0);
        finish_prog(1'b0);
        select(ctl(spd_pkg::CMD_PAGE_1), 1'b1);
        stop();
        check_bit(active_page, 1'b1, "page select");
        write_mem(8'h85, '{8'h5a}, 1'b0);
        hv = 1'b1;
        select(ctl(spd_pkg::CMD_CLEAR_PROTECT), 1'b1);
        stop();
        finish_prog(1'bx);
        hv = 1'b0;
        write_mem(8'h85, '{8'h5a}, 1'b1);
        finish_prog(1'b1);
        read_mem(8'h85, '{8'h5a});
        select(ctl(spd_pkg::CMD_PAGE_0), 1'b1);
        stop();
        check_bit(active_page, 1'b0, "page select");
        read_mem(8'h85, '{8'hff});
    endtask : t_protect

    task automatic t_supply();
        open_read(8'h00);
        check_bit(sda_oe, 1'b1, "read bit driven");
        supply_ok = 1'b0;
        tick(2);
        check_bit(sda_oe, 1'b0, "release on supply loss");
        stop();
        select(mem_sel(1'b1), 1'b0);
        stop();
        supply_ok = 1'b1;
        tick(2);
        read_mem(8'h0e, '{8'h11});
    endtask : t_supply

    task automatic t_timeout();
        open_read(8'h00);
        check_bit(sda_oe, 1'b1, "read bit driven");
        tick(TMO + 20);
        check_bit(sda_oe, 1'b0, "release on timeout");
        stop();
        read_mem(8'h00, '{8'h33});
    endtask : t_timeout

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (5) @(posedge clock);
        #1;
        rst = 1'b0;
        tick(2);
        t_write_wrap();
        t_busy_refuse();
        t_address_refuse();
        t_protect();
        t_supply();
        t_timeout();
        print_verdict();
    end

    // Some seven thousand cycles are needed; this allows over eight times that.
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : tb
